// ### host_bus_port.sv
// Parallel host bus port of a four-channel UART
//
// Behaviour
// [RULE_01] In strobe style a falling read strobe starts a read and the byte is driven out.
// [RULE_02] In strobe style a write runs from falling write strobe and loads data at its rise.
// [RULE_03] In select style the write strobe pin is read/write: high reads, low writes.
// [RULE_04] In select style the read strobe pin is ignored and held high by the host.
// [RULE_05] In strobe style each of four active-low selects enables one channel A to D.
// [RULE_06] In select style the channel A select is the single device select.
// [RULE_07] In select style the channel B and C selects are two channel-address bits.
// [RULE_08] In select style the channel D select has no use and is tied high outside.
// [RULE_09] In strobe style each interrupt pin floats while its output-enable bit is 0.
// [RULE_10] In select style channel A interrupt pin is an open-drain active-low device request.
// [RULE_11] In select style interrupt pins B, C and D are held at logic zero.
// [RULE_12] The shared transmit flag is the AND of the four active-low transmit-ready signals.
// [RULE_13] The shared receive flag is the AND of the four active-low receive-ready signals.
// [RULE_14] Address is three bits, data is eight bits, driven only during reads.
// [RULE_15] In strobe style the force input drives all interrupt pins whatever the enable bits.
// [RULE_16] In select style the host holds the force input low.
// [RULE_17] In select style address bits A4,A3 pick channels A,B,C,D; any pending request asserts.
`timescale 1ns/10ps
`default_nettype none
`include "host_bus_port_map.svh"

module host_bus_port (
	input  wire logic       CLK_SYS,          // 20 MHz system clock
	input  wire logic       RST,              // Async reset, active high
	input  wire logic       BUS_STYLE_SEL,    // High: strobe style, low: select style
	input  wire logic       IRQ_FORCE_ENABLE, // Force interrupt pins driven in strobe style
	input  wire logic       READ_STROBE_N,    // Read strobe pin
	input  wire logic       WRITE_STROBE_N,   // Write strobe or read/write pin
	input  wire logic       CHAN_A_SELECT_N,  // Select A or device select
	input  wire logic       CHAN_B_SELECT_N,  // Select B or address A3
	input  wire logic       CHAN_C_SELECT_N,  // Select C or address A4
	input  wire logic       CHAN_D_SELECT_N,  // Select D, unused in select style
	input  wire logic [2:0] ADDR,             // Register address pins
	input  wire logic [7:0] DATA_IN,          // Data bus level seen at pins
	output logic      [7:0] DATA_OUT,         // Data driven on reads
	output logic            DATA_OE_N,        // Low while driving data bus
	output logic      [1:0] REG_CHAN,         // Channel of register access
	output logic      [2:0] REG_ADDR,         // Register within channel
	output logic            REG_RD_STB,       // One-cycle read request
	output logic            REG_WR_STB,       // One-cycle write request
	output logic      [7:0] REG_WR_DATA,      // Data for write request
	input  wire logic [7:0] REG_RD_DATA,      // Read data, valid with read request
	input  wire logic [3:0] CHAN_IRQ,         // Pending interrupt per channel
	input  wire logic [3:0] CHAN_OUT_EN,      // Output-enable bit per channel
	input  wire logic [3:0] TX_READY_N,       // Transmit ready per channel
	input  wire logic [3:0] RX_READY_N,       // Receive ready per channel
	output logic      [3:0] INT_OUT,          // Interrupt pin levels
	output logic      [3:0] INT_OE_N,         // Low while interrupt pin driven
	output logic            TX_SPACE_FLAG_N,  // Shared transmit ready
	output logic            RX_AVAIL_FLAG_N   // Shared receive ready
);
	import host_bus_port_pkg::*;

	port_state_t q;
	port_state_t d;
	pin_vec_t    pins;
	pin_vec_t    agree;
	logic [1:0]  acc_now;
	logic [1:0]  acc_was;

	// Access kind of a filtered pin vector: bit 1 read, bit 0 write
	function automatic logic [1:0] access_of(input pin_vec_t f);
		logic sel;
		sel = 1'b0;
		if (f[`P_STYLE]) begin
			sel = ~&f[`P_CSD:`P_CSA];                     // see [RULE_05]
			access_of = {sel & ~f[`P_RD], sel & ~f[`P_WR]}; // see [RULE_01] see [RULE_02]
		end else begin
			sel = ~f[`P_CSA];                               // see [RULE_06]
			// Read strobe and select D not looked at here
			access_of = {sel & f[`P_WR], sel & ~f[`P_WR]};  // see [RULE_03] see [RULE_04] see [RULE_08]
		end
	endfunction

	// Channel addressed by a filtered pin vector
	function automatic logic [1:0] chan_of(input pin_vec_t f);
		if (!f[`P_STYLE])
			chan_of = {f[`P_CSC], f[`P_CSB]};               // see [RULE_07] see [RULE_17]
		else if (!f[`P_CSA])
			chan_of = `CHAN_A;
		else if (!f[`P_CSB])
			chan_of = `CHAN_B;
		else if (!f[`P_CSC])
			chan_of = `CHAN_C;
		else
			chan_of = `CHAN_D;
	endfunction

	assign pins = {BUS_STYLE_SEL, IRQ_FORCE_ENABLE, READ_STROBE_N, WRITE_STROBE_N,
		CHAN_D_SELECT_N, CHAN_C_SELECT_N, CHAN_B_SELECT_N, CHAN_A_SELECT_N, ADDR, DATA_IN};
	assign agree = ~(q.s2 ^ q.s3);

	always_comb begin
		d = q;
		d.s1 = pins;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// Filtered pin takes the new level once stages two and three agree
		d.f = (q.f & ~agree) | (q.s2 & agree);
		acc_now = access_of(d.f);
		acc_was = access_of(q.f);
		d.rd_stb = 1'b0;
		d.wr_stb = 1'b0;
		unique case (q.st)
			ST_IDLE: begin
				if (acc_now[1] && !acc_was[1]) begin
					d.rd_stb = 1'b1;                            // see [RULE_01]
					d.cap = 1'b1;
					d.chan = chan_of(d.f);
					d.addr = d.f[`P_ADDR_HI:`P_ADDR_LO];        // see [RULE_14]
					d.st = ST_READ;
				end else if (acc_now[0] && !acc_was[0]) begin
					d.chan = chan_of(d.f);                      // see [RULE_02]
					d.addr = d.f[`P_ADDR_HI:`P_ADDR_LO];
					d.st = ST_WRITE;
				end
			end
			ST_READ: begin
				if (q.cap) begin
					d.dout = REG_RD_DATA;
					d.oe_n = 1'b0;                              // see [RULE_14]
					d.cap = 1'b0;
				end
				if (!acc_now[1]) begin
					d.oe_n = 1'b1;
					d.cap = 1'b0;
					d.st = ST_IDLE;
				end
			end
			ST_WRITE: begin
				if (!acc_now[0]) begin
					// Data as sampled just before the write access ended (write strobe or select rose)
					d.wdata = q.f[`P_DATA_HI:0];                // see [RULE_02]
					d.wr_stb = 1'b1;                            // see [RULE_03]
					d.st = ST_IDLE;
				end
			end
			// Illegal one-hot code falls back to idle
			default: d.st = ST_IDLE;
		endcase
		if (q.f[`P_STYLE]) begin
			d.int_out = CHAN_IRQ;
			// Force input only counts in strobe style
			d.int_oe_n = ~(CHAN_OUT_EN | {4{q.f[`P_FORCE]}}); // see [RULE_09] see [RULE_15]
		end else begin
			d.int_out = 4'h0;                                  // see [RULE_11]
			d.int_oe_n = {3'h0, ~|CHAN_IRQ};                   // see [RULE_10] see [RULE_16]
		end
		d.txf_n = &TX_READY_N;                                 // see [RULE_12]
		d.rxf_n = &RX_READY_N;                                 // see [RULE_13]
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			q.s1 <= `PIN_RST;
			q.s2 <= `PIN_RST;
			q.s3 <= `PIN_RST;
			q.f <= `PIN_RST;
			q.st <= ST_IDLE;
			q.cap <= 1'b0;
			q.chan <= `CHAN_A;
			q.addr <= 3'h0;
			q.dout <= `DOUT_RST;
			q.oe_n <= 1'b1;
			q.rd_stb <= 1'b0;
			q.wr_stb <= 1'b0;
			q.wdata <= `DOUT_RST;
			q.int_out <= 4'h0;
			q.int_oe_n <= 4'hf;
			q.txf_n <= 1'b1;
			q.rxf_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign DATA_OUT = q.dout;
	assign DATA_OE_N = q.oe_n;
	assign REG_CHAN = q.chan;
	assign REG_ADDR = q.addr;
	assign REG_RD_STB = q.rd_stb;
	assign REG_WR_STB = q.wr_stb;
	assign REG_WR_DATA = q.wdata;
	assign INT_OUT = q.int_out;
	assign INT_OE_N = q.int_oe_n;
	assign TX_SPACE_FLAG_N = q.txf_n;
	assign RX_AVAIL_FLAG_N = q.rxf_n;

	property p_rd_data;
		@(posedge CLK_SYS) disable iff (RST)
		(REG_RD_STB && access_of(d.f) == 2'b10) |=>
			(!DATA_OE_N && DATA_OUT == $past(REG_RD_DATA));
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read byte not driven"); // see [RULE_01]

	property p_oe_read_only;
		@(posedge CLK_SYS) disable iff (RST)
		!DATA_OE_N |-> (q.st == ST_READ);
	endproperty
	a_oe_read_only: assert property (p_oe_read_only) else $error("bus driven outside read"); // see [RULE_14]

	property p_wr_after_access;
		@(posedge CLK_SYS) disable iff (RST)
		REG_WR_STB |-> ($past(q.st) == ST_WRITE && q.st == ST_IDLE && !REG_RD_STB);
	endproperty
	a_wr_after_access: assert property (p_wr_after_access) else $error("stray write"); // see [RULE_02]

	property p_sel_style_rw;
		@(posedge CLK_SYS) disable iff (RST)
		(REG_RD_STB && !q.f[`P_STYLE]) |-> (q.f[`P_WR] && !q.f[`P_CSA]);
	endproperty
	a_sel_style_rw: assert property (p_sel_style_rw) else $error("read without r/w high"); // see [RULE_03]

	property p_strobe_chan;
		@(posedge CLK_SYS) disable iff (RST)
		(REG_RD_STB && q.f[`P_STYLE]) |-> !q.f[`P_CSA + REG_CHAN];
	endproperty
	a_strobe_chan: assert property (p_strobe_chan) else $error("channel not selected"); // see [RULE_05]

	property p_addr_chan;
		@(posedge CLK_SYS) disable iff (RST)
		(REG_RD_STB && !q.f[`P_STYLE]) |-> (REG_CHAN == {q.f[`P_CSC], q.f[`P_CSB]});
	endproperty
	a_addr_chan: assert property (p_addr_chan) else $error("wrong channel decode"); // see [RULE_17]

	property p_int_enable;
		@(posedge CLK_SYS) disable iff (RST)
		q.f[`P_STYLE] ##1 q.f[`P_STYLE] |->
			(INT_OE_N == ~($past(CHAN_OUT_EN) | {4{$past(q.f[`P_FORCE])}}));
	endproperty
	a_int_enable: assert property (p_int_enable) else $error("interrupt enable wrong"); // see [RULE_09]

	property p_int_open_drain;
		@(posedge CLK_SYS) disable iff (RST)
		!q.f[`P_STYLE] |=> (!INT_OUT[0] && INT_OE_N[0] == ~|$past(CHAN_IRQ));
	endproperty
	a_int_open_drain: assert property (p_int_open_drain) else $error("device request wrong"); // see [RULE_10]

	property p_int_unused_low;
		@(posedge CLK_SYS) disable iff (RST)
		!q.f[`P_STYLE] |=> (INT_OUT[3:1] == 3'h0 && INT_OE_N[3:1] == 3'h0);
	endproperty
	a_int_unused_low: assert property (p_int_unused_low) else $error("unused pins not low"); // see [RULE_11]

	property p_flags;
		@(posedge CLK_SYS) disable iff (RST)
		##1 (TX_SPACE_FLAG_N == &$past(TX_READY_N) && RX_AVAIL_FLAG_N == &$past(RX_READY_N));
	endproperty
	a_flags: assert property (p_flags) else $error("shared flag wrong"); // see [RULE_12] see [RULE_13]

	// Access handshake: pulse shapes and captured bytes
	property p_rd_pulse;
		@(posedge CLK_SYS) disable iff (RST)
		REG_RD_STB |=> !REG_RD_STB;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse long"); // see [RULE_01]

	property p_rd_from_idle;
		@(posedge CLK_SYS) disable iff (RST)
		REG_RD_STB |-> ($past(q.st) == ST_IDLE && q.st == ST_READ);
	endproperty
	a_rd_from_idle: assert property (p_rd_from_idle) else $error("rd start"); // see [RULE_01]

	property p_oe_release;
		@(posedge CLK_SYS) disable iff (RST)
		(!DATA_OE_N && (access_of(d.f) & 2'h2) == 2'h0) |=> DATA_OE_N;
	endproperty
	a_oe_release: assert property (p_oe_release) else $error("bus held"); // see [RULE_14]

	property p_wr_data;
		@(posedge CLK_SYS) disable iff (RST)
		REG_WR_STB |-> (REG_WR_DATA == $past(q.f[`P_DATA_HI:0]));
	endproperty
	a_wr_data: assert property (p_wr_data) else $error("write byte wrong"); // see [RULE_02]

	property p_wr_pulse;
		@(posedge CLK_SYS) disable iff (RST)
		REG_WR_STB |=> !REG_WR_STB;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse long"); // see [RULE_02]

	property p_sel_style_wr;
		@(posedge CLK_SYS) disable iff (RST)
		(REG_WR_STB && !$past(q.f[`P_STYLE])) |->
			(!$past(q.f[`P_WR]) && !$past(q.f[`P_CSA]));
	endproperty
	a_sel_style_wr: assert property (p_sel_style_wr) else $error("bad write"); // see [RULE_03]

	// Interrupt pins in strobe style
	property p_int_force;
		@(posedge CLK_SYS) disable iff (RST)
		(q.f[`P_STYLE] && q.f[`P_FORCE]) |=> (INT_OE_N == 4'h0);
	endproperty
	a_int_force: assert property (p_int_force) else $error("force ignored"); // see [RULE_15]

	property p_int_follow;
		@(posedge CLK_SYS) disable iff (RST)
		q.f[`P_STYLE] |=> (INT_OUT == $past(CHAN_IRQ));
	endproperty
	a_int_follow: assert property (p_int_follow) else $error("interrupt level wrong"); // see [RULE_09]

endmodule // host_bus_port
`default_nettype wire

// ### host_bus_port_map.svh
// Pin vector layout, reset values and field positions of the host bus port
`ifndef HOST_BUS_PORT_MAP_SVH
`define HOST_BUS_PORT_MAP_SVH
`define PIN_W      19
`define P_DATA_HI  7
`define P_ADDR_LO  8
`define P_ADDR_HI  10
`define P_CSA      11
`define P_CSB      12
`define P_CSC      13
`define P_CSD      14
`define P_WR       15
`define P_RD       16
`define P_FORCE    17
`define P_STYLE    18
`define PIN_RST    19'h5f800
`define DOUT_RST   8'h00
`define CHAN_A     2'h0
`define CHAN_B     2'h1
`define CHAN_C     2'h2
`define CHAN_D     2'h3
`endif

// ### host_bus_port_pkg.sv
// Types of the host bus port: access states and the state record
`include "host_bus_port_map.svh"
package host_bus_port_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_READ  = 3'h2,
		ST_WRITE = 3'h4
	} acc_state_t;
	typedef logic [`PIN_W-1:0] pin_vec_t;
	typedef struct packed {
		pin_vec_t   s1;
		pin_vec_t   s2;
		pin_vec_t   s3;
		pin_vec_t   f;
		acc_state_t st;
		logic       cap;
		logic [1:0] chan;
		logic [2:0] addr;
		logic [7:0] dout;
		logic       oe_n;
		logic       rd_stb;
		logic       wr_stb;
		logic [7:0] wdata;
		logic [3:0] int_out;
		logic [3:0] int_oe_n;
		logic       txf_n;
		logic       rxf_n;
	} port_state_t;
endpackage

// ### host_cpu_model.sv
// Host processor model driving the bus pins of the port
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model (
	input  wire logic       clk,   // System clock
	input  wire logic       style, // Bus style in use
	input  wire logic [7:0] dout,  // Device read data
	input  wire logic       doe_n, // Device data drive, low
	input  wire logic       wstb,  // Write request pulse
	output logic            rd_n,  // Read strobe
	output logic            wr_n,  // Write strobe or r/w
	output logic      [3:0] sel_n, // Select pins D..A
	output logic      [2:0] addr,  // Address pins
	output logic      [7:0] din,   // Resolved data bus
	output logic            late   // Set once a wait ran out
);
	logic       drv;
	logic [7:0] wd;
	logic [7:0] last;
	// Floating bus keeps toggling so no stale byte survives
	assign din = drv ? wd : (doe_n === 1'b0 ? dout : ~last);
	always @(posedge clk) last <= din;
	initial begin
		rd_n = 1'b1;
		wr_n = 1'b1;
		sel_n = 4'hf;
		addr = 3'h0;
		drv = 1'b0;
		wd = 8'h00;
		last = 8'h00;
		late = 1'b0;
	end
	task automatic acc(input logic rd, input logic [1:0] ch, input logic [2:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wd <= d;
		drv <= !rd;
		if (style) begin
			sel_n <= ~(4'h1 << ch);
			if (rd) rd_n <= 1'b0;
			else wr_n <= 1'b0;
		end else begin
			sel_n <= {1'b1, ch, 1'b0};
			wr_n <= rd;
		end
		repeat (6) @(posedge clk);
		while (rd && doe_n !== 1'b0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20)
			late <= 1'b1;
		q = dout;
		rd_n <= 1'b1;
		sel_n <= 4'hf;
		if (style) wr_n <= 1'b1;
		n = 0;
		while ((rd ? doe_n !== 1'b1 : wstb !== 1'b1) && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20)
			late <= 1'b1;
		drv <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule // host_cpu_model
`default_nettype wire

// ### quad_uart_host_bus_port_test.sv
// Self-checking bench of the host bus port
`timescale 1ns/10ps
`default_nettype none
module quad_uart_host_bus_port_test;
	import host_bus_port_pkg::*;
	logic CLK_SYS, RST, BUS_STYLE_SEL, IRQ_FORCE_ENABLE, DATA_OE_N, REG_RD_STB, REG_WR_STB;
	logic TX_SPACE_FLAG_N, RX_AVAIL_FLAG_N, rd_n, wr_n;
	logic [3:0] sel_n, CHAN_IRQ, CHAN_OUT_EN, TX_READY_N, RX_READY_N, INT_OUT, INT_OE_N;
	logic [2:0] addr, REG_ADDR;
	logic [1:0] REG_CHAN;
	logic [7:0] din, DATA_OUT, REG_WR_DATA, REG_RD_DATA;
	logic [7:0] ref_mem [32];
	logic [7:0] regs [32];
	logic [4:0] wkey;
	int mismatches, samples_checked;
	int rd_seen, wr_seen;
	logic late;
	host_bus_port dut (.CLK_SYS(CLK_SYS), .RST(RST), .BUS_STYLE_SEL(BUS_STYLE_SEL),
		.IRQ_FORCE_ENABLE(IRQ_FORCE_ENABLE), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
		.CHAN_A_SELECT_N(sel_n[0]), .CHAN_B_SELECT_N(sel_n[1]), .CHAN_C_SELECT_N(sel_n[2]),
		.CHAN_D_SELECT_N(sel_n[3]), .ADDR(addr), .DATA_IN(din), .DATA_OUT(DATA_OUT),
		.DATA_OE_N(DATA_OE_N), .REG_CHAN(REG_CHAN), .REG_ADDR(REG_ADDR), .REG_RD_STB(REG_RD_STB),
		.REG_WR_STB(REG_WR_STB), .REG_WR_DATA(REG_WR_DATA), .REG_RD_DATA(REG_RD_DATA),
		.CHAN_IRQ(CHAN_IRQ), .CHAN_OUT_EN(CHAN_OUT_EN), .TX_READY_N(TX_READY_N),
		.RX_READY_N(RX_READY_N), .INT_OUT(INT_OUT), .INT_OE_N(INT_OE_N),
		.TX_SPACE_FLAG_N(TX_SPACE_FLAG_N), .RX_AVAIL_FLAG_N(RX_AVAIL_FLAG_N));
	host_cpu_model host (.clk(CLK_SYS), .style(BUS_STYLE_SEL), .dout(DATA_OUT),
		.doe_n(DATA_OE_N), .wstb(REG_WR_STB), .rd_n(rd_n), .wr_n(wr_n), .sel_n(sel_n),
		.addr(addr), .din(din), .late(late));
	assign REG_RD_DATA = regs[{REG_CHAN, REG_ADDR}];
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: data %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [5:0] got, input logic [5:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: pins %b expected %b", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checked %0d, mismatched %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Register file behind the port, with strobe counts
	always @(posedge CLK_SYS) begin
		if (REG_RD_STB === 1'b1)
			rd_seen++;
		if (REG_WR_STB === 1'b1) begin
			wr_seen++;
			regs[{REG_CHAN, REG_ADDR}] <= REG_WR_DATA;
			chk({3'h0, REG_CHAN, REG_ADDR}, {3'h0, wkey});
			chk(REG_WR_DATA, ref_mem[wkey]);
		end
	end
	task automatic bus_test(input logic style);
		logic [2:0] a;
		logic [7:0] q;
		logic [1:0] o;
		int r0;
		int w0;
		BUS_STYLE_SEL <= style;
		repeat (6) @(posedge CLK_SYS);
		r0 = rd_seen;
		w0 = wr_seen;
		for (int c = 0; c < 4; c++) begin
			a = 3'($urandom());
			o = 2'(c + 1);
			wkey = {c[1:0], a};
			ref_mem[wkey] = 8'($urandom());
			host.acc(1'b0, c[1:0], a, ref_mem[wkey], q);
			host.acc(1'b1, c[1:0], a, 8'h00, q);
			chk(q, ref_mem[{c[1:0], a}]);
			host.acc(1'b1, o, a, 8'h00, q);
			chk(q, ref_mem[{o, a}]);
		end
		chk(8'(rd_seen - r0), 8'h08);
		chk(8'(wr_seen - w0), 8'h04);
		$display("bus test style %0d done", style);
	endtask
	task automatic irq_test(input logic style);
		logic [3:0] e;
		logic [3:0] p;
		for (int k = 0; k < 12; k++) begin
			@(posedge CLK_SYS);
			BUS_STYLE_SEL <= style;
			CHAN_IRQ <= 4'($urandom());
			CHAN_OUT_EN <= 4'($urandom());
			TX_READY_N <= (k < 2) ? 4'hf : 4'($urandom());
			RX_READY_N <= (k < 2) ? 4'hf : 4'($urandom());
			IRQ_FORCE_ENABLE <= style ? 1'($urandom()) : 1'b0;
			repeat (6) @(posedge CLK_SYS);
			for (int i = 0; i < 4; i++) begin
				p[i] = INT_OE_N[i] ? 1'bz : INT_OUT[i];
				e[i] = (CHAN_OUT_EN[i] | IRQ_FORCE_ENABLE) ? CHAN_IRQ[i] : 1'bz;
			end
			if (!style) e = {3'h0, (|CHAN_IRQ) ? 1'b0 : 1'bz};
			chk_pin({4'h0, TX_SPACE_FLAG_N, RX_AVAIL_FLAG_N}, {4'h0, &TX_READY_N, &RX_READY_N});
			chk_pin({2'h0, p}, {2'h0, e});
		end
		$display("interrupt test style %0d done", style);
	endtask
	initial begin
		CLK_SYS = 1'b0;
		forever #25 CLK_SYS = ~CLK_SYS;
	end
	initial begin
		#(5000 * 50);
		mismatches++;
		final_report();
	end
	initial begin
		void'($urandom(57684));
		RST = 1'b1;
		BUS_STYLE_SEL = 1'b1;
		IRQ_FORCE_ENABLE = 1'b0;
		CHAN_IRQ = 4'h0;
		CHAN_OUT_EN = 4'h0;
		TX_READY_N = 4'hf;
		RX_READY_N = 4'hf;
		wkey = 5'h00;
		for (int i = 0; i < 32; i++) begin
			ref_mem[i] = 8'(i * 11 + 3);
			regs[i] = ref_mem[i];
		end
		repeat (8) @(posedge CLK_SYS);
		RST <= 1'b0;
		repeat (6) @(posedge CLK_SYS);
		bus_test(1'b1);
		bus_test(1'b0);
		irq_test(1'b1);
		irq_test(1'b0);
		chk({7'h0, late}, 8'h00);
		final_report();
	end
endmodule // quad_uart_host_bus_port_test
`default_nettype wire
